/* logic/rsapd_pkg.sv */
// Purpose: Shared constants and types for the RS-232 power-mode controller
// Assumes: pclk at 40 MHz, APB with 32-bit data
// Notes: Times are kept in their own units; cycle counts derive from them
package rsapd_pkg;
  // Clock and timebase
  localparam longint CLK_HZ = 40_000_000;
  localparam longint TICK_US = 1000;          // Timebase tick period, us
  localparam longint TICK_CYC = (TICK_US * CLK_HZ) / 1_000_000;
  localparam longint WAKE_US = 100;           // Device wake-up latency, us
  localparam longint WAKE_CYC = (WAKE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint STARTUP_MS = 100;        // Forced-on window after reset
  localparam longint STARTUP_TICKS = (STARTUP_MS * 1000) / TICK_US;
  localparam longint IDLE_S = 30;             // Device inactivity timeout
  localparam longint IDLE_TICKS = (IDLE_S * 1_000_000) / TICK_US;
  localparam int TICK_W = 16;
  localparam int IDLE_W = 15;
  localparam int WAKE_W = 13;
  localparam int START_W = 7;

  // Channel counts and FIFO shape
  localparam int NTX = 3;
  localparam int NRX = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CNT_W = 4;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] TXDATA_OFF = 12'h008;
  localparam logic [11:0] BAUD_OFF = 12'h00c;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SWON_BIT = 3;
  localparam int CTRL_WAITRDY_BIT = 4;
  localparam int CTRL_USED_LSB = 8;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0710;
  localparam logic [15:0] BAUD_RST = 16'h0015;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'b000,
    MODE_FORCE_ON = 3'b001,
    MODE_FORCE_OFF = 3'b010,
    MODE_VALID_ON = 3'b011,
    MODE_VALID_BOTH = 3'b100,
    MODE_SOFT = 3'b101
  } rsapd_mode_e;

  // Pins read from the transceiver
  typedef struct packed {
    logic level_valid_out;
    logic pump_ready;
    logic ring_monitor_out;
    logic [NRX-1:0] rx_out;
  } rsapd_dev_in_s;

  // Pins driven into the transceiver
  typedef struct packed {
    logic force_on_a;
    logic force_off_n;
    logic [NTX-1:0] tx_in;
  } rsapd_dev_out_s;
endpackage

/* logic/rsapd_fifo.sv */
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes: Full and empty are exact; count reports occupancy
`timescale 1ns/1ps
`default_nettype none
module rsapd_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  input wire logic pclk,                     // Clock
  input wire logic presetn,                  // Async reset, active low
  input wire logic in_valid,                 // Write request
  output logic in_ready,                     // Space available
  input wire logic [WIDTH-1:0] in_data,      // Write data
  output logic out_valid,                    // Data available
  input wire logic out_ready,                // Read accept
  output logic [WIDTH-1:0] out_data,         // Head data
  output logic [$clog2(DEPTH):0] count       // Occupancy
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshakes and pointer arithmetic
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Pointer and count registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage, one write port per entry
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= '0;
        end else if (push && wp_r == AW'(g)) begin
          mem_r[g] <= in_data;
        end
      end
    end
  endgenerate

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign count = cnt_r;
endmodule
`default_nettype wire

/* logic/rsapd_ctrl.sv */
// Purpose: Host-side power-mode and transmit controller for an RS-232 transceiver
// Assumes: APB slave for software, transceiver pins asynchronous to pclk
// Notes: Transmit words are paced out of an 8-word FIFO at the baud tick
// What this block does
// - force_on_a from level_valid: sleep only without valid level and edges.
// - Both forces from level_valid: sleep exactly while no valid level.
// - Controller forces transmitters on for 100 ms after power-up, except in forced-off mode.
// - Software shutdown drives both force controls from one signal.
// - Unused transmitter inputs are tied to a fixed logic level.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rsapd_ctrl #(
  parameter int unsigned TICK_CYCLES = 40000,   // Cycles per timebase tick
  parameter int unsigned IDLE_TICKS_P = 30000   // Ticks to device idle timeout
) (
  input wire logic pclk,                        // 40 MHz clock
  input wire logic presetn,                     // Async reset, active low
  input wire logic psel,                        // APB select
  input wire logic penable,                     // APB enable
  input wire logic pwrite,                      // APB direction
  input wire logic [11:0] paddr,                // APB byte address
  input wire logic [31:0] pwdata,               // APB write data
  output logic [31:0] prdata,                   // APB read data
  output logic pready,                          // APB ready
  output logic pslverr,                         // APB error
  input wire rsapd_pkg::rsapd_dev_in_s dev_in,  // Transceiver status pins
  output rsapd_pkg::rsapd_dev_out_s dev_out     // Transceiver control pins
);
  localparam int NTX = rsapd_pkg::NTX;
  localparam int CW = rsapd_pkg::FIFO_CNT_W;

  // Register state
  logic [31:0] ctrl_r, ctrl_nxt, prdata_r, prdata_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  // Pin state
  rsapd_pkg::rsapd_dev_in_s s1_r, s2_r, s3_r;
  rsapd_pkg::rsapd_dev_out_s out_r, out_nxt;
  // Timers
  logic [rsapd_pkg::TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [rsapd_pkg::START_W-1:0] start_cnt_r, start_cnt_nxt;
  logic [rsapd_pkg::IDLE_W-1:0] idle_cnt_r, idle_cnt_nxt;
  logic [rsapd_pkg::WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;
  logic [15:0] baud_cnt_r, baud_cnt_nxt;
  logic tick, baud_tick, startup, idle_done, awake, tx_ready, edge_seen;
  // FIFO link
  logic push, fifo_in_ready, fifo_out_valid, pop;
  logic [NTX-1:0] fifo_data;
  logic [CW-1:0] fifo_cnt;
  rsapd_pkg::rsapd_mode_e mode;
  logic [NTX-1:0] used;
  logic mapped, commit;

  assign mode = rsapd_pkg::rsapd_mode_e'(ctrl_r[rsapd_pkg::CTRL_MODE_LSB +: 3]);
  assign used = ctrl_r[rsapd_pkg::CTRL_USED_LSB +: NTX];

  // Two-stage synchroniser plus history stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= dev_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // APB decode, read mux and register writes
  always_comb begin
    mapped = (paddr == rsapd_pkg::CTRL_OFF) || (paddr == rsapd_pkg::STATUS_OFF) ||
             (paddr == rsapd_pkg::TXDATA_OFF) || (paddr == rsapd_pkg::BAUD_OFF);
    commit = psel && penable && pready_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    ctrl_nxt = ctrl_r;
    baud_nxt = baud_r;
    push = 1'b0;
    if (psel && !pready_r) begin
      // TXDATA write waits while the FIFO is full
      if (!(pwrite && paddr == rsapd_pkg::TXDATA_OFF && !fifo_in_ready)) begin
        pready_nxt = 1'b1;
        pslverr_nxt = !mapped;
        prdata_nxt = 32'h0000_0000;
        if (!pwrite && paddr == rsapd_pkg::CTRL_OFF) begin
          prdata_nxt = ctrl_r;
        end else if (!pwrite && paddr == rsapd_pkg::STATUS_OFF) begin
          // Receiver outputs are shown as the inverted logic the device delivers
          prdata_nxt = {16'h0000, fifo_cnt, tx_ready, idle_done, startup, awake,
                        s2_r.rx_out, s2_r.ring_monitor_out, s2_r.pump_ready,
                        s2_r.level_valid_out};
        end else if (!pwrite && paddr == rsapd_pkg::BAUD_OFF) begin
          prdata_nxt = {16'h0000, baud_r};
        end
      end
    end
    if (commit && pwrite) begin
      if (paddr == rsapd_pkg::CTRL_OFF) begin
        ctrl_nxt = {21'h00_0000, pwdata[10:8], 3'b000, pwdata[4:0]};
      end else if (paddr == rsapd_pkg::BAUD_OFF) begin
        baud_nxt = pwdata[15:0];
      end else if (paddr == rsapd_pkg::TXDATA_OFF) begin
        push = 1'b1;
      end
    end
  end

  // APB register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= rsapd_pkg::CTRL_RST;
      baud_r <= rsapd_pkg::BAUD_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      baud_r <= baud_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Transmit word buffer
  rsapd_fifo #(
    .WIDTH(NTX),
    .DEPTH(rsapd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[NTX-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .count(fifo_cnt)
  );

  // Force-control decode, startup override and transmit pacing
  always_comb begin
    out_nxt = out_r;
    unique case (mode)
      rsapd_pkg::MODE_AUTO: begin
        out_nxt.force_on_a = 1'b0;
        out_nxt.force_off_n = 1'b1;
      end
      rsapd_pkg::MODE_FORCE_ON: begin
        out_nxt.force_on_a = 1'b1;
        out_nxt.force_off_n = 1'b1;
      end
      rsapd_pkg::MODE_FORCE_OFF: begin
        out_nxt.force_on_a = 1'b0;
        out_nxt.force_off_n = 1'b0;
      end
      rsapd_pkg::MODE_VALID_ON: begin
        out_nxt.force_on_a = s2_r.level_valid_out;
        out_nxt.force_off_n = 1'b1;
      end
      rsapd_pkg::MODE_VALID_BOTH: begin
        out_nxt.force_on_a = s2_r.level_valid_out;
        out_nxt.force_off_n = s2_r.level_valid_out;
      end
      rsapd_pkg::MODE_SOFT: begin
        out_nxt.force_on_a = ctrl_r[rsapd_pkg::CTRL_SWON_BIT];
        out_nxt.force_off_n = ctrl_r[rsapd_pkg::CTRL_SWON_BIT];
      end
      default: begin
        out_nxt.force_on_a = 1'b0;
        out_nxt.force_off_n = 1'b1;
      end
    endcase
    // Wake-up window after reset, unless mode is forced off
    if (startup && mode != rsapd_pkg::MODE_FORCE_OFF) begin
      out_nxt.force_on_a = 1'b1;
      out_nxt.force_off_n = 1'b1;
    end
    pop = fifo_out_valid && tx_ready && baud_tick;
    if (pop) begin
      out_nxt.tx_in = fifo_data;
    end
    out_nxt.tx_in = (out_nxt.tx_in & used) | ~used;
  end

  // Predicted device state: forced off wins, then forced on, then idle timer
  always_comb begin
    if (!out_r.force_off_n) begin
      awake = 1'b0;
    end else if (out_r.force_on_a) begin
      awake = 1'b1;
    end else begin
      awake = !idle_done;
    end
  end

  // Edges on transmit pins, and on receiver outputs while they are driven
  assign edge_seen = (out_nxt.tx_in != out_r.tx_in) ||
                     ((s2_r.rx_out != s3_r.rx_out) && out_r.force_off_n);
  assign tick = (tick_cnt_r == rsapd_pkg::TICK_W'(TICK_CYCLES - 1));
  assign baud_tick = (baud_cnt_r >= baud_r);
  assign startup = (start_cnt_r != rsapd_pkg::START_W'(rsapd_pkg::STARTUP_TICKS));
  assign idle_done = (idle_cnt_r == rsapd_pkg::IDLE_W'(IDLE_TICKS_P));
  // Transmit only once awake, settled, and optionally pump_ready high
  assign tx_ready = awake && (wake_cnt_r == rsapd_pkg::WAKE_W'(rsapd_pkg::WAKE_CYC)) &&
                    (s2_r.pump_ready || !ctrl_r[rsapd_pkg::CTRL_WAITRDY_BIT]);

  // Timer next values
  always_comb begin
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    baud_cnt_nxt = baud_tick ? 16'h0000 : baud_cnt_r + 16'h0001;
    start_cnt_nxt = (startup && tick) ? start_cnt_r + 1'b1 : start_cnt_r;
    idle_cnt_nxt = idle_cnt_r;
    if (edge_seen) begin
      idle_cnt_nxt = '0;
    end else if (tick && !idle_done) begin
      idle_cnt_nxt = idle_cnt_r + 1'b1;
    end
    wake_cnt_nxt = wake_cnt_r;
    if (!awake) begin
      wake_cnt_nxt = '0;
    end else if (wake_cnt_r != rsapd_pkg::WAKE_W'(rsapd_pkg::WAKE_CYC)) begin
      wake_cnt_nxt = wake_cnt_r + 1'b1;
    end
  end

  // Timer and pin registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      baud_cnt_r <= 16'h0000;
      start_cnt_r <= '0;
      idle_cnt_r <= '0;
      wake_cnt_r <= '0;
      out_r <= '{force_on_a: 1'b1, force_off_n: 1'b1, tx_in: '1};
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      baud_cnt_r <= baud_cnt_nxt;
      start_cnt_r <= start_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dev_out = out_r;
endmodule
`default_nettype wire

/* test/rsapd_ctrl_checker.sv */
// Purpose: Port assertions for rsapd_ctrl
// Assumes: Bound to the top module
// Notes: Startup age counted in cycles
`timescale 1ns/1ps
`default_nettype none
module rsapd_ctrl_checker #(
  parameter int unsigned TICK_CYCLES = 40000
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire rsapd_pkg::rsapd_dev_in_s dev_in, // Pins in
  input wire rsapd_pkg::rsapd_dev_out_s dev_out // Pins out
);
  logic [31:0] up_r;
  logic [31:0] up_nxt;
  logic wr_ctrl;
  // Cycles since reset, saturating
  always_comb up_nxt = up_r[31] ? up_r : up_r + 32'h0000_0001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_r <= 32'h0000_0000;
    else up_r <= up_nxt;
  end
  // Completed control write
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == rsapd_pkg::CTRL_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_next: assert property (psel && !penable && !(pwrite && paddr == rsapd_pkg::TXDATA_OFF) |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_zero_data: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0000_0000) else $error("data not 0");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h00c |-> pslverr)
    else $error("unmapped not refused");
  a_off_wins: assert property (wr_ctrl && pwdata[2:0] == 3'h2 |-> ##[1:2] !dev_out.force_off_n)
    else $error("force off ignored");
  a_soft_tied: assert property (wr_ctrl && pwdata[2:0] == 3'h5 && up_r > 101 * TICK_CYCLES
    |-> ##[1:2] dev_out.force_on_a == dev_out.force_off_n) else $error("soft pins differ");
  a_startup_on: assert property (up_r < 99 * TICK_CYCLES && dev_out.force_off_n |-> dev_out.force_on_a)
    else $error("startup not forced on");
  a_tx_hold_off: assert property (!dev_out.force_off_n && !$past(dev_out.force_off_n) && !$past(psel)
    |-> $stable(dev_out.tx_in)) else $error("tx moved while off");
  c_soft: cover property (wr_ctrl && pwdata[2:0] == 3'h5);
  c_err: cover property (pslverr);
  c_off: cover property ($fell(dev_out.force_off_n));
endmodule
bind rsapd_ctrl rsapd_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dev_in(dev_in), .dev_out(dev_out));
`default_nettype wire

/* test/rsapd_dev_model.sv */
// Purpose: Behavioural transceiver seen by the controller
// Assumes: pclk used only as a timebase
// Notes: Released receiver outputs toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module rsapd_dev_model #(
  parameter int IDLE_CYC = 50,
  parameter int WAKE_CYC = 200
) (
  input wire logic pclk, // Timebase
  input wire rsapd_pkg::rsapd_dev_out_s ctl, // Controls
  input wire logic [4:0] line_rx, // Line, 1 positive
  input wire logic line_valid, // Valid level seen
  output rsapd_pkg::rsapd_dev_in_s pins // To host
);
  int idle = 0;
  int wk = 0;
  logic awake;
  logic [4:0] rx_q = 5'h00;
  logic [4:0] line_q = 5'h00;
  logic [2:0] tx_q = 3'h7;
  // Mode priority, then automatic power-down
  assign awake = ctl.force_off_n && (ctl.force_on_a || idle < IDLE_CYC);
  // Inactivity timer, pump settle and released outputs
  always @(posedge pclk) begin
    if (ctl.tx_in !== tx_q || line_rx !== line_q) idle <= 0;
    else if (idle < IDLE_CYC) idle <= idle + 1;
    tx_q <= ctl.tx_in;
    line_q <= line_rx;
    wk <= awake ? ((wk < WAKE_CYC) ? wk + 1 : wk) : 0;
    rx_q <= ~rx_q;
  end
  // Pins toward the host
  assign pins = '{level_valid_out: line_valid,
                  pump_ready: awake && wk >= WAKE_CYC,
                  ring_monitor_out: line_rx[1],
                  rx_out: ctl.force_off_n ? ~line_rx : rx_q};
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: Directed APB tests of rsapd_ctrl
// Assumes: Short tick and idle counts
// Notes: Expected values worked out here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rsapd_pkg::rsapd_dev_in_s dev_in;
  rsapd_pkg::rsapd_dev_out_s dev_out;
  logic [4:0] line_rx = 5'h15;
  logic line_valid = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cyc0 = 0;
  int t_first = 0;
  int m;
  logic [2:0] txq [$];
  logic [2:0] tx_last = 3'h7;
  logic [31:0] rd;
  logic er;
  logic [1:0] ex;
  always #12.5 pclk = ~pclk;
  rsapd_ctrl #(.TICK_CYCLES(10), .IDLE_TICKS_P(5)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_in(dev_in), .dev_out(dev_out));
  rsapd_dev_model #(.IDLE_CYC(50), .WAKE_CYC(200)) u_dev (.pclk(pclk), .ctl(dev_out), .line_rx(line_rx),
    .line_valid(line_valid), .pins(dev_in));
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, result in rd and er
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog and record of transmit changes
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
    if (presetn && dev_out.tx_in !== tx_last) begin
      if (txq.size() == 0) t_first = cyc;
      txq.push_back(dev_out.tx_in);
      tx_last = dev_out.tx_in;
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("start", {dev_out.force_on_a, dev_out.force_off_n}, 2'h3);
    apb(1'b0, rsapd_pkg::CTRL_OFF, 32'h0000_0000);
    chk("ctrl", rd, rsapd_pkg::CTRL_RST);
    apb(1'b0, rsapd_pkg::BAUD_OFF, 32'h0000_0000);
    chk("baud", rd, 32'h0000_0015);
    apb(1'b1, 12'h010, 32'h0000_0001);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    apb(1'b1, rsapd_pkg::STATUS_OFF, 32'hffff_ffff);
    chk("ro", er, 1'b0);
    repeat (1100) @(posedge pclk);
    // Every mode, without and with a valid level
    for (int lv = 0; lv < 2; lv++) begin
      line_valid <= lv[0];
      for (int i = 0; i < 7; i++) begin
        m = (i > 5) ? 5 : i;
        apb(1'b1, rsapd_pkg::CTRL_OFF, 32'h0000_0510 | 32'(m) | ((i == 6) ? 32'h0000_0008 : 32'h0000_0000));
        repeat (6) @(posedge pclk);
        case (m)
          0: ex = 2'h1;
          1: ex = 2'h3;
          3: ex = {lv[0], 1'b1};
          4: ex = {2{lv[0]}};
          default: ex = {2{i == 6}};
        endcase
        if (m == 2) chk("off_n", dev_out.force_off_n, 1'b0);
        else chk("pins", {dev_out.force_on_a, dev_out.force_off_n}, ex);
        apb(1'b0, rsapd_pkg::STATUS_OFF, 32'h0000_0000);
        chk("ring_valid", {rd[2], rd[0]}, {line_rx[1], lv[0]});
        if (m == 1) chk("rx", rd[7:3], {27'h000_0000, ~line_rx});
      end
    end
    // Idle timeout, then wake on a receiver edge; undefined mode 6 acts as automatic
    apb(1'b1, rsapd_pkg::CTRL_OFF, 32'h0000_0516);
    repeat (200) @(posedge pclk);
    chk("mode6", {dev_out.force_on_a, dev_out.force_off_n}, 2'h1);
    apb(1'b0, rsapd_pkg::STATUS_OFF, 32'h0000_0000);
    chk("idle", {rd[10], rd[8]}, 2'h2);
    line_rx <= line_rx ^ 5'h01;
    repeat (10) @(posedge pclk);
    apb(1'b0, rsapd_pkg::STATUS_OFF, 32'h0000_0000);
    chk("wake", {rd[10], rd[8]}, 2'h1);
    // Fill FIFO while forced off, drain after wake
    apb(1'b1, rsapd_pkg::CTRL_OFF, 32'h0000_0512);
    apb(1'b1, rsapd_pkg::BAUD_OFF, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    txq.delete();
    for (int i = 0; i < 8; i++) apb(1'b1, rsapd_pkg::TXDATA_OFF, 32'(i));
    apb(1'b0, rsapd_pkg::STATUS_OFF, 32'h0000_0000);
    chk("count", rd[15:12], 4'h8);
    chk("held", txq.size(), 0);
    cyc0 = cyc;
    apb(1'b1, rsapd_pkg::CTRL_OFF, 32'h0000_0511);
    for (int k = 0; k < 9000 && txq.size() < 8; k++) @(posedge pclk);
    chk("latency", t_first - cyc0 >= 4000, 1'b1);
    for (int i = 0; i < 8; i++) chk("tx", txq[i], 3'(i) | 3'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, rsapd_pkg::STATUS_OFF, 32'h0000_0000);
    chk("drained", rd[15:12], 4'h0);
    conclude();
  end
endmodule
`default_nettype wire
